// ---- rtl/dialer_pkg.sv ----
// Shared constants, timing figures and carrier types of the pulse/tone dialing sequencer.
package dialer_pkg;

   // Clock and reference tick.
   localparam int CLK_HZ = 125_000_000;
   localparam int TICK_MS = 1;
   localparam int CYCLES_PER_TICK = CLK_HZ / 1000 * TICK_MS;

   // Durations in milliseconds.
   localparam int DEBOUNCE_MS = 32;
   localparam int PRE_SIGNAL_MS = 100;
   localparam int TONE_ON_MS = 98;
   localparam int TONE_GAP_MS = 102;
   localparam int FIXED_DELAY_MS = 1100;
   localparam int SEP_PULSE_MS = 900;
   localparam int SEP_TONE_MS = 100;
   localparam int PAUSE_TONE_MS = 1500;
   localparam int FLASH_BREAK_MS = 600;
   localparam int FLASH_TOTAL_MS = 2100;
   localparam int PULSE_BREAK_MS = 60;
   localparam int PULSE_MAKE_MS = 40;

   // Durations in reference ticks.
   localparam int TW = 12;
   localparam logic [TW-1:0] T_DEBOUNCE = TW'(DEBOUNCE_MS / TICK_MS);
   localparam logic [TW-1:0] T_PRE = TW'(PRE_SIGNAL_MS / TICK_MS);
   localparam logic [TW-1:0] T_TONE_ON = TW'(TONE_ON_MS / TICK_MS);
   localparam logic [TW-1:0] T_TONE_GAP = TW'(TONE_GAP_MS / TICK_MS);
   localparam logic [TW-1:0] T_SEP_PULSE = TW'(SEP_PULSE_MS / TICK_MS);
   localparam logic [TW-1:0] T_SPECIAL_PULSE = TW'((SEP_PULSE_MS + FIXED_DELAY_MS + SEP_PULSE_MS) / TICK_MS);
   localparam logic [TW-1:0] T_MODE_TONE = TW'((SEP_TONE_MS + FIXED_DELAY_MS + SEP_TONE_MS) / TICK_MS);
   localparam logic [TW-1:0] T_PAUSE_TONE = TW'(PAUSE_TONE_MS / TICK_MS);
   localparam logic [TW-1:0] T_FLASH_BREAK = TW'(FLASH_BREAK_MS / TICK_MS);
   localparam logic [TW-1:0] T_FLASH_REST = TW'((FLASH_TOTAL_MS - FLASH_BREAK_MS) / TICK_MS);
   localparam logic [TW-1:0] T_BREAK = TW'(PULSE_BREAK_MS / TICK_MS);
   localparam logic [TW-1:0] T_MAKE = TW'(PULSE_MAKE_MS / TICK_MS);

   // Last-number buffer.
   localparam int BUF_DEPTH = 16;
   localparam logic [4:0] BUF_FULL = 5'h10;

   // Key codes are {row, column}; the fourth column holds the special functions.
   localparam logic [3:0] KEY_MODE = 4'h3;
   localparam logic [3:0] KEY_PAUSE = 4'h7;
   localparam logic [3:0] KEY_FLASH = 4'hB;
   localparam logic [3:0] KEY_REDIAL = 4'hF;
   localparam logic [3:0] KEY_ZERO = 4'hD;
   localparam logic [3:0] PULSES_ZERO = 4'hA;

   typedef struct packed {
      logic ok;
      logic [1:0] idx;
   } line_sel_t;

   typedef struct packed {
      logic on;
      logic [1:0] row;
      logic [1:0] col;
   } tone_sel_t;

   typedef enum logic [1:0] {K_IDLE, K_DEB, K_REL} key_st_t;

   typedef enum logic [3:0] {
      D_IDLE, D_PRE, D_LOAD, D_TONE_ON, D_TONE_GAP, D_BREAK, D_MAKE,
      D_SEP, D_SPECIAL, D_FLASH_BRK, D_FLASH_WAIT
   } dial_st_t;

   typedef struct packed {
      logic [16:0] pre;
      logic tick;
      logic scan_col;
      line_sel_t row;
      line_sel_t col;
      key_st_t kst;
      dial_st_t dst;
      logic [BUF_DEPTH-1:0][3:0] num_buf;
      logic [4:0] wr;
      logic [4:0] rd;
      logic fresh;
      logic redial;
      logic toggle;
      logic hook_prev;
      logic [3:0] pcnt;
      tone_sel_t tone;
      logic brk;
      logic mute;
   } dial_state_t;

endpackage

// ---- rtl/sync2.sv ----
// Two-stage synchroniser for pin levels entering the core clock domain.
module sync2 #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.s2;

endmodule

// ---- rtl/ms_timer.sv ----
// Down counter in reference ticks that pulses done when a loaded length has run out.
module ms_timer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic load,
   input wire logic [dialer_pkg::TW-1:0] len,
   output logic done
);

   typedef struct packed {
      logic [dialer_pkg::TW-1:0] count;
      logic done;
   } timer_state_t;

   timer_state_t s_r;
   timer_state_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (load)
      begin
         s_nxt.count = len;
      end
      else if (tick && s_r.count != '0)
      begin
         s_nxt.count = s_r.count - 1'b1;
         s_nxt.done = (s_r.count == dialer_pkg::TW'(1));
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign done = s_r.done;

   timer_load_a: assert property (@(posedge core_clk) disable iff (rst)
      load |=> s_r.count == $past(len))
      else $error("Timer did not take the loaded length.");

endmodule

// ---- rtl/dial_sequencer.sv ----
// Keypad entry, last-number buffer and tone/pulse signaling sequencer.
module dial_sequencer #(
   parameter int TICK_CYCLES = dialer_pkg::CYCLES_PER_TICK
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hook_switch_input,
   input wire logic mode_select,
   input wire logic [3:0] row_in,
   input wire logic [3:0] col_in,
   output logic [3:0] row_oe,
   output logic [3:0] col_oe,
   output dialer_pkg::tone_sel_t tone,
   output logic pulse_out_oe,
   output logic speech_mute_output_oe
);

   dialer_pkg::dial_state_t s_r;
   dialer_pkg::dial_state_t s_nxt;
   logic [9:0] pins_s;
   logic hook_on;
   logic mode_pin;
   logic [3:0] row_s;
   logic [3:0] col_s;
   logic tone_mode;
   logic key_present;
   logic deb_load;
   logic deb_done;
   logic seq_load;
   logic [dialer_pkg::TW-1:0] seq_len;
   logic seq_done;
   logic [3:0] code;
   logic [4:0] rd_inc;
   logic [3:0] pc;

   sync2 #(.W(10)) pin_sync (
      .core_clk(core_clk),
      .rst(rst),
      .d({hook_switch_input, mode_select, row_in, col_in}),
      .q(pins_s)
   );

   assign hook_on = pins_s[9];
   assign mode_pin = pins_s[8];
   assign row_s = pins_s[7:4];
   assign col_s = pins_s[3:0];

   ms_timer deb_timer (
      .core_clk(core_clk),
      .rst(rst),
      .tick(s_r.tick),
      .load(deb_load),
      .len(dialer_pkg::T_DEBOUNCE),
      .done(deb_done)
   );

   ms_timer seq_timer (
      .core_clk(core_clk),
      .rst(rst),
      .tick(s_r.tick),
      .load(seq_load),
      .len(seq_len),
      .done(seq_done)
   );

   // A line counts only when exactly one of its four inputs is low.
   function automatic dialer_pkg::line_sel_t low_one(input logic [3:0] p);
      dialer_pkg::line_sel_t r;
      r = '0;
      unique case (p)
         4'hE: r = '{ok: 1'b1, idx: 2'h0};
         4'hD: r = '{ok: 1'b1, idx: 2'h1};
         4'hB: r = '{ok: 1'b1, idx: 2'h2};
         4'h7: r = '{ok: 1'b1, idx: 2'h3};
         default: r = '0;
      endcase
      return r;
   endfunction

   // Star, hash and the spare codes give no loop breaks in pulse mode.
   function automatic logic [3:0] pulses_of(input logic [3:0] c);
      logic [3:0] r;
      r = 4'h0;
      if (c == dialer_pkg::KEY_ZERO)
      begin
         r = dialer_pkg::PULSES_ZERO;
      end
      else if (c[3:2] != 2'h3 && c[1:0] != 2'h3)
      begin
         r = 4'({2'h0, c[3:2]} * 4'h3 + {2'h0, c[1:0]} + 4'h1);
      end
      return r;
   endfunction

   assign tone_mode = mode_pin ^ s_r.toggle;
   assign key_present = s_r.row.ok && s_r.col.ok;
   assign code = s_r.num_buf[s_r.rd[3:0]];
   assign rd_inc = s_r.rd + 5'h1;
   assign pc = pulses_of(code);

   always_comb
   begin
      s_nxt = s_r;
      deb_load = 1'b0;
      seq_load = 1'b0;
      seq_len = '0;

      // One shared reference tick times every delay of the block.
      s_nxt.tick = 1'b0;
      if (s_r.pre == 17'(TICK_CYCLES - 1))
      begin
         s_nxt.pre = '0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.pre = s_r.pre + 17'h1;
      end

      // Off-hook one group is sampled per tick while the other is held low.
      if (s_r.tick)
      begin
         if (hook_on)
         begin
            s_nxt.row = low_one(row_s);
            s_nxt.col = low_one(col_s);
         end
         else
         begin
            if (s_r.scan_col)
            begin
               s_nxt.col = low_one(col_s);
            end
            else
            begin
               s_nxt.row = low_one(row_s);
            end
            s_nxt.scan_col = !s_r.scan_col;
         end
      end

      // Keys are taken into the buffer independently of signaling.
      unique case (s_r.kst)
         dialer_pkg::K_IDLE:
         begin
            if (key_present)
            begin
               deb_load = 1'b1;
               s_nxt.kst = dialer_pkg::K_DEB;
            end
         end
         dialer_pkg::K_DEB:
         begin
            if (deb_done)
            begin
               s_nxt.kst = key_present ? dialer_pkg::K_REL : dialer_pkg::K_IDLE;
               if (key_present && {s_r.row.idx, s_r.col.idx} == dialer_pkg::KEY_REDIAL)
               begin
                  if (s_r.dst == dialer_pkg::D_IDLE && s_r.fresh && s_r.wr != 5'h0 && !hook_on)
                  begin
                     s_nxt.rd = 5'h0;
                     s_nxt.redial = 1'b1;
                  end
               end
               else if (key_present && s_r.fresh)
               begin
                  s_nxt.num_buf[0] = {s_r.row.idx, s_r.col.idx};
                  s_nxt.wr = 5'h1;
                  s_nxt.rd = 5'h0;
                  s_nxt.fresh = 1'b0;
                  s_nxt.redial = 1'b0;
               end
               else if (key_present && s_r.wr != dialer_pkg::BUF_FULL)
               begin
                  s_nxt.num_buf[s_r.wr[3:0]] = {s_r.row.idx, s_r.col.idx};
                  s_nxt.wr = s_r.wr + 5'h1;
               end
            end
         end
         dialer_pkg::K_REL:
         begin
            if (!s_r.row.ok && !s_r.col.ok)
            begin
               s_nxt.kst = dialer_pkg::K_IDLE;
            end
         end
         default:
         begin
            s_nxt.kst = dialer_pkg::K_IDLE;
         end
      endcase

      // Signaling of buffered entries, one at a time in entry order.
      unique case (s_r.dst)
         dialer_pkg::D_IDLE:
         begin
            if (!hook_on && s_r.rd < s_r.wr)
            begin
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_PRE;
               s_nxt.dst = dialer_pkg::D_PRE;
            end
         end
         dialer_pkg::D_PRE, dialer_pkg::D_TONE_GAP, dialer_pkg::D_SEP,
         dialer_pkg::D_SPECIAL, dialer_pkg::D_FLASH_WAIT:
         begin
            if (seq_done)
            begin
               s_nxt.dst = (s_r.rd < s_r.wr) ? dialer_pkg::D_LOAD : dialer_pkg::D_IDLE;
            end
         end
         dialer_pkg::D_LOAD:
         begin
            s_nxt.rd = rd_inc;
            if (code == dialer_pkg::KEY_FLASH && s_r.redial)
            begin
               s_nxt.dst = (rd_inc < s_r.wr) ? dialer_pkg::D_LOAD : dialer_pkg::D_IDLE;
            end
            else if (code == dialer_pkg::KEY_MODE)
            begin
               s_nxt.toggle = !s_r.toggle;
               seq_load = 1'b1;
               seq_len = tone_mode ? dialer_pkg::T_MODE_TONE : dialer_pkg::T_SPECIAL_PULSE;
               s_nxt.dst = dialer_pkg::D_SPECIAL;
            end
            else if (code == dialer_pkg::KEY_PAUSE)
            begin
               seq_load = 1'b1;
               seq_len = tone_mode ? dialer_pkg::T_PAUSE_TONE : dialer_pkg::T_SPECIAL_PULSE;
               s_nxt.dst = dialer_pkg::D_SPECIAL;
            end
            else if (code == dialer_pkg::KEY_FLASH)
            begin
               s_nxt.brk = 1'b1;
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_FLASH_BREAK;
               s_nxt.dst = dialer_pkg::D_FLASH_BRK;
            end
            else if (tone_mode)
            begin
               s_nxt.tone = '{on: 1'b1, row: code[3:2], col: code[1:0]};
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_TONE_ON;
               s_nxt.dst = dialer_pkg::D_TONE_ON;
            end
            else if (pc == 4'h0)
            begin
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_SEP_PULSE;
               s_nxt.dst = dialer_pkg::D_SEP;
            end
            else
            begin
               s_nxt.brk = 1'b1;
               s_nxt.pcnt = pc;
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_BREAK;
               s_nxt.dst = dialer_pkg::D_BREAK;
            end
         end
         dialer_pkg::D_TONE_ON:
         begin
            if (seq_done)
            begin
               s_nxt.tone.on = 1'b0;
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_TONE_GAP;
               s_nxt.dst = dialer_pkg::D_TONE_GAP;
            end
         end
         dialer_pkg::D_BREAK:
         begin
            if (seq_done)
            begin
               s_nxt.brk = 1'b0;
               s_nxt.pcnt = s_r.pcnt - 4'h1;
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_MAKE;
               s_nxt.dst = dialer_pkg::D_MAKE;
            end
         end
         dialer_pkg::D_MAKE:
         begin
            if (seq_done)
            begin
               seq_load = 1'b1;
               if (s_r.pcnt == 4'h0)
               begin
                  seq_len = dialer_pkg::T_SEP_PULSE;
                  s_nxt.dst = dialer_pkg::D_SEP;
               end
               else
               begin
                  s_nxt.brk = 1'b1;
                  seq_len = dialer_pkg::T_BREAK;
                  s_nxt.dst = dialer_pkg::D_BREAK;
               end
            end
         end
         dialer_pkg::D_FLASH_BRK:
         begin
            if (seq_done)
            begin
               s_nxt.brk = 1'b0;
               seq_load = 1'b1;
               seq_len = dialer_pkg::T_FLASH_REST;
               s_nxt.dst = dialer_pkg::D_FLASH_WAIT;
            end
         end
         default:
         begin
            s_nxt.dst = dialer_pkg::D_IDLE;
         end
      endcase

      // A hook change wins over everything; the stored number is kept for redial.
      s_nxt.hook_prev = hook_on;
      if (hook_on != s_r.hook_prev)
      begin
         s_nxt.dst = dialer_pkg::D_IDLE;
         s_nxt.kst = dialer_pkg::K_IDLE;
         // A key may be stored in this same cycle, so the read side follows the new write pointer.
         s_nxt.rd = s_nxt.wr;
         s_nxt.fresh = 1'b1;
         s_nxt.redial = 1'b0;
         s_nxt.toggle = 1'b0;
         s_nxt.tone = '0;
         s_nxt.brk = 1'b0;
         s_nxt.pcnt = 4'h0;
      end

      s_nxt.mute = (s_nxt.dst != dialer_pkg::D_IDLE);
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.fresh <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign row_oe = (hook_on || !s_r.scan_col) ? 4'h0 : 4'hF;
   assign col_oe = (hook_on || s_r.scan_col) ? 4'h0 : 4'hF;
   assign tone = s_r.tone;
   assign pulse_out_oe = s_r.brk;
   assign speech_mute_output_oe = s_r.mute;

   on_hook_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      hook_on |-> row_oe == 4'h0 && col_oe == 4'h0)
      else $error("Keypad driven while on-hook.");

   pre_delay_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(s_r.mute) |-> !s_r.tone.on && !s_r.brk && s_r.dst == dialer_pkg::D_PRE)
      else $error("Signaling began without the pre-signal delay.");

   mute_signal_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.tone.on || s_r.brk) |-> speech_mute_output_oe)
      else $error("Mute released while signaling.");

   tone_break_excl_a: assert property (@(posedge core_clk) disable iff (rst)
      !(s_r.tone.on && s_r.brk))
      else $error("Tone burst and line break at once.");

   flash_break_a: assert property (@(posedge core_clk) disable iff (rst)
      s_r.dst == dialer_pkg::D_FLASH_BRK |-> pulse_out_oe)
      else $error("Flash break not on the pulse output.");

   hook_init_a: assert property (@(posedge core_clk) disable iff (rst)
      (hook_on != s_r.hook_prev) |=> s_r.dst == dialer_pkg::D_IDLE && !s_r.toggle && !s_r.brk)
      else $error("Hook change did not initialise dialing.");

   default_mode_a: assert property (@(posedge core_clk) disable iff (rst)
      !s_r.toggle |-> tone_mode == mode_pin)
      else $error("Default mode does not follow the mode pin.");

   buffer_bound_a: assert property (@(posedge core_clk) disable iff (rst)
      s_r.wr <= dialer_pkg::BUF_FULL && s_r.rd <= s_r.wr)
      else $error("Buffer pointers out of order.");

   start_dial_a: assert property (@(posedge core_clk) disable iff (rst)
      (s_r.dst == dialer_pkg::D_IDLE && !hook_on && s_r.hook_prev == hook_on && s_r.rd < s_r.wr)
      |=> s_r.dst == dialer_pkg::D_PRE && s_r.mute)
      else $error("Stored digit did not start dialing with mute.");

endmodule

// ---- verif/keypad_model.sv ----
// Keypad and hookswitch model: a single-contact keypad on pulled-up lines with a negative common.
module keypad_model (
   input wire logic hook_switch_input,
   input wire logic pressed,
   input wire logic [1:0] key_row,
   input wire logic [1:0] key_col,
   input wire logic [3:0] row_oe,
   input wire logic [3:0] col_oe,
   output logic [3:0] row_in,
   output logic [3:0] col_in
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb
   begin
      // Undriven lines sit at the pull-up level, never at a stale value.
      row_in = ~row_oe;
      col_in = ~col_oe;
      if (pressed)
      begin
         // On-hook only the common can pull a line low; off-hook the contact copies the driven side.
         if (hook_switch_input | col_oe[key_col])
            row_in[key_row] = 1'b0;
         if (hook_switch_input | row_oe[key_row])
            col_in[key_col] = 1'b0;
      end
   end
endmodule

// ---- verif/dial_sequencer_tb.sv ----
// Self-checking testbench of the dialing sequencer with a keypad and hookswitch model.
module dial_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 4;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hook = 1'b0;
   logic mode_sel = 1'b1;
   logic pressed = 1'b0;
   logic [1:0] kr = 2'h0;
   logic [1:0] kc = 2'h0;
   logic [3:0] row_in;
   logic [3:0] col_in;
   logic [3:0] row_oe;
   logic [3:0] col_oe;
   dialer_pkg::tone_sel_t tone;
   logic pulse_oe;
   logic mute_oe;
   logic [2:0] obs;
   int failures = 0;
   int n_checks = 0;
   int el;
   int n;

   always #4 core_clk = ~core_clk;
   assign obs = {mute_oe, pulse_oe, tone.on};

   dial_sequencer #(.TICK_CYCLES(TC)) i_dial_sequencer (
      .core_clk(core_clk),
      .rst(rst),
      .hook_switch_input(hook),
      .mode_select(mode_sel),
      .row_in(row_in),
      .col_in(col_in),
      .row_oe(row_oe),
      .col_oe(col_oe),
      .tone(tone),
      .pulse_out_oe(pulse_oe),
      .speech_mute_output_oe(mute_oe)
   );

   keypad_model i_keypad_model (
      .hook_switch_input(hook),
      .pressed(pressed),
      .key_row(kr),
      .key_col(kc),
      .row_oe(row_oe),
      .col_oe(col_oe),
      .row_in(row_in),
      .col_in(col_in)
   );

   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %0t %s seen %0d expected %0d", $time, m, seen, exp);
      end
   endtask

   // Tick phase makes every duration uncertain by about one tick, hence the window.
   task automatic near(input int cyc, input int t, input string m);
      int d;
      d = cyc - t * TC;
      check(32'((d <= 5 && d >= -5) ? t : cyc / TC), 32'(t), m);
   endtask

   task automatic ticks(input int k);
      repeat (k * TC) @(negedge core_clk);
   endtask

   task automatic wait_obs(input int b, input logic v, input int lim);
      el = 0;
      while (obs[b] !== v)
      begin
         @(negedge core_clk);
         el++;
         if (el > lim * TC)
         begin
            failures++;
            $display("BAD %0t output did not change in time", $time);
            finish_test();
         end
      end
   endtask

   task automatic key(input logic [1:0] r, input logic [1:0] c);
      @(negedge core_clk);
      kr = r;
      kc = c;
      pressed = 1'b1;
      ticks(45);
      pressed = 1'b0;
      ticks(8);
   endtask

   task automatic hook_cycle(input logic m);
      mode_sel = m;
      hook = 1'b1;
      ticks(6);
      hook = 1'b0;
      ticks(6);
   endtask

   task automatic tone_is(input logic [1:0] r, input logic [1:0] c);
      wait_obs(0, 1'b0, 200);
      wait_obs(0, 1'b1, 3000);
      check(32'(tone.row), 32'(r), "tone row");
      check(32'(tone.col), 32'(c), "tone column");
   endtask

   // Counts break starts until mute drops.
   task automatic count_breaks(output int cnt);
      logic p;
      cnt = 0;
      p = pulse_oe;
      for (int k = 0; k < 4000 * TC && mute_oe === 1'b1; k++)
      begin
         @(negedge core_clk);
         if (pulse_oe === 1'b1 && p !== 1'b1)
            cnt++;
         p = pulse_oe;
      end
      check(32'(mute_oe), 32'h0, "digit did not end in time");
   endtask

   task automatic t_tone_digit;
      hook_cycle(1'b1);
      fork
         key(2'h1, 2'h1);
         begin
            wait_obs(2, 1'b1, 40);
            tone_is(2'h1, 2'h1);
            near(el, 100, "pre-signal delay");
            wait_obs(0, 1'b0, 200);
            near(el, 98, "burst length");
            wait_obs(2, 1'b0, 300);
            near(el, 102, "gap with mute held");
         end
      join
      $display("tone digit done");
   endtask

   task automatic t_pulse_zero;
      hook_cycle(1'b0);
      fork
         key(2'h3, 2'h1);
         begin
            wait_obs(2, 1'b1, 40);
            wait_obs(1, 1'b1, 200);
            near(el, 100, "pulse pre-signal delay");
            wait_obs(1, 1'b0, 100);
            near(el, 60, "break length");
            wait_obs(1, 1'b1, 100);
            near(el, 40, "make length");
            count_breaks(n);
            check(32'(n), 32'h8, "breaks after the second");
         end
      join
      $display("pulse zero done");
   endtask

   task automatic t_abort;
      hook_cycle(1'b0);
      key(2'h2, 2'h2);
      wait_obs(1, 1'b1, 200);
      hook = 1'b1;
      ticks(2);
      check(32'({mute_oe, pulse_oe}), 32'h0, "abort on hook change");
      key(2'h0, 2'h0);
      check(32'(mute_oe), 32'h0, "on-hook key signaled");
      $display("abort done");
   endtask

   task automatic t_burst_redial;
      hook_cycle(1'b1);
      for (int pass = 0; pass < 2; pass++)
      begin
         fork
            if (pass == 0)
            begin
               key(2'h0, 2'h0);
               key(2'h0, 2'h1);
               key(2'h0, 2'h2);
            end
            else
               key(2'h3, 2'h3);
            begin
               tone_is(2'h0, 2'h0);
               tone_is(2'h0, 2'h1);
               tone_is(2'h0, 2'h2);
            end
         join
         wait_obs(2, 1'b0, 400);
         hook_cycle(1'b1);
      end
      $display("burst and redial done");
   endtask

   task automatic t_pause;
      hook_cycle(1'b1);
      fork
         begin
            key(2'h0, 2'h0);
            key(2'h1, 2'h3);
            key(2'h0, 2'h1);
         end
         begin
            tone_is(2'h0, 2'h0);
            wait_obs(0, 1'b0, 200);
            tone_is(2'h0, 2'h1);
            near(el, 102 + 1500, "pause delay");
         end
      join
      wait_obs(2, 1'b0, 400);
      $display("pause done");
   endtask

   task automatic t_toggle;
      hook_cycle(1'b1);
      fork
         begin
            key(2'h0, 2'h0);
            key(2'h0, 2'h3);
            key(2'h0, 2'h1);
         end
         begin
            tone_is(2'h0, 2'h0);
            wait_obs(0, 1'b0, 200);
            wait_obs(1, 1'b1, 2000);
            near(el, 102 + 1300, "toggle delay");
            count_breaks(n);
            check(32'(n), 32'h1, "digit after toggle");
         end
      join
      hook_cycle(1'b1);
      fork
         key(2'h3, 2'h3);
         begin
            tone_is(2'h0, 2'h0);
            wait_obs(1, 1'b1, 2000);
            count_breaks(n);
            check(32'(n), 32'h1, "toggle on redial");
         end
      join
      $display("toggle done");
   endtask

   task automatic t_flash;
      hook_cycle(1'b1);
      fork
         begin
            key(2'h2, 2'h3);
            key(2'h0, 2'h0);
         end
         begin
            wait_obs(1, 1'b1, 300);
            wait_obs(1, 1'b0, 700);
            near(el, 600, "flash break");
            tone_is(2'h0, 2'h0);
            near(el, 1500, "flash remainder");
         end
      join
      wait_obs(2, 1'b0, 400);
      hook_cycle(1'b1);
      fork
         key(2'h3, 2'h3);
         begin
            wait_obs(2, 1'b1, 100);
            tone_is(2'h0, 2'h0);
            near(el, 100, "flash skipped on redial");
         end
      join
      wait_obs(2, 1'b0, 400);
      $display("flash done");
   endtask

   initial
   begin
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      ticks(4);
      t_tone_digit();
      t_pulse_zero();
      t_abort();
      t_burst_redial();
      t_pause();
      t_toggle();
      t_flash();
      finish_test();
   end
endmodule
